// >>> core/ifatl_pkg.sv
// Constants, field layouts and carrier structs for the input function and alarm trip logic.
// Assumes a single 100 MHz clock and a plain register port on the host side.
// How it works
// - Code 7 zeroes ramp times and rounding
// - Code 8 selects alternative speed gains
// - Autotune writes into selected gain set
// - Code 9 suppresses minimum speed reference in positive-only or negative-only polarity
// - Code 10 open raises external fail one
// - Codes 17/18 open raise fails two/three
// - Code 11 forces field for programmed time
// - Codes 12/13 pick one of three jogs
// - Codes 14/15 ramp motor pot if used
// - Code 16 clears motor pot instantly
// - Codes 19/20 drive timer outputs delayed
// - Shared codes combine as logical OR
// - Slave current reference clamps at limit
// - Mains alarms delayed up to 2000 ms
// - Undervoltage delay only above 3/4, no regen
// - Serial silence beyond delay raises alarm
// - Fieldbus silence beyond delay raises alarm
// - Inhibit bits block three alarms
// - Code 0 clears the stored alarm
// - Code 6 bypasses speed loop and ramps
package ifatl_pkg;
  localparam int NUM_IN = 6;
  localparam int CODE_W = 5;
  localparam int REF_W = 16;
  localparam int CLK_MHZ = 100;
  localparam int CYC_PER_MS = CLK_MHZ * 1000;
  localparam int CYC_PER_10MS = CYC_PER_MS * 10;
  localparam logic [CODE_W-1:0] FN_RESET = 5'h00;
  localparam logic [CODE_W-1:0] FN_SLAVE = 5'h06;
  localparam logic [CODE_W-1:0] FN_RAMP_OFF = 5'h07;
  localparam logic [CODE_W-1:0] FN_ALT_SET = 5'h08;
  localparam logic [CODE_W-1:0] FN_MINSPD_OFF = 5'h09;
  localparam logic [CODE_W-1:0] FN_EXT1 = 5'h0a;
  localparam logic [CODE_W-1:0] FN_FLD_FORCE = 5'h0b;
  localparam logic [CODE_W-1:0] FN_JOG_A = 5'h0c;
  localparam logic [CODE_W-1:0] FN_JOG_B = 5'h0d;
  localparam logic [CODE_W-1:0] FN_UP = 5'h0e;
  localparam logic [CODE_W-1:0] FN_DN = 5'h0f;
  localparam logic [CODE_W-1:0] FN_POT_CLR = 5'h10;
  localparam logic [CODE_W-1:0] FN_EXT2 = 5'h11;
  localparam logic [CODE_W-1:0] FN_EXT3 = 5'h12;
  localparam logic [CODE_W-1:0] FN_TIMER_A = 5'h13;
  localparam logic [CODE_W-1:0] FN_TIMER_B = 5'h14;
  // Register map, word index on the plain port
  localparam logic [3:0] REG_FUNC_LO = 4'h0;
  localparam logic [3:0] REG_FUNC_HI = 4'h1;
  localparam logic [3:0] REG_MAINS_DLY = 4'h2;
  localparam logic [3:0] REG_SER_DLY = 4'h3;
  localparam logic [3:0] REG_FBUS_DLY = 4'h4;
  localparam logic [3:0] REG_INHIBIT = 4'h5;
  localparam logic [3:0] REG_FLD_TIME = 4'h6;
  localparam logic [3:0] REG_POT_RATE = 4'h7;
  localparam logic [3:0] REG_TIMER_A = 4'h8;
  localparam logic [3:0] REG_TIMER_B = 4'h9;
  localparam logic [3:0] REG_CUR_LIMIT = 4'ha;
  localparam logic [3:0] REG_MISC = 4'hb;
  localparam logic [3:0] REG_ALARMS = 4'hc;
  localparam logic [3:0] REG_POT_REF = 4'hd;
  localparam logic [3:0] REG_STATUS = 4'he;
  localparam logic [15:0] MAINS_DLY_RST = 16'h03e8;
  localparam logic [15:0] MAINS_DLY_MAX = 16'h07d0;
  localparam logic [15:0] LINK_DLY_RST = 16'h0064;
  localparam logic [15:0] LINK_DLY_MIN = 16'h0064;
  localparam logic [15:0] LINK_DLY_MAX = 16'h2710;
  localparam int INH_FLD = 0;
  localparam int INH_LOAD = 1;
  localparam int INH_FREQ = 2;
  localparam int MISC_POL_LO = 0;
  localparam int MISC_POT_USED = 2;
  localparam int MISC_SER_SRC = 3;
  localparam int MISC_FBUS_SRC = 4;
  localparam logic [1:0] POL_POS_ONLY = 2'h1;
  localparam logic [1:0] POL_NEG_ONLY = 2'h2;

  typedef struct packed {
    logic field_failure_alarm;
    logic load_loss_alarm;
    logic unstable_freq_alarm;
    logic mains_overvoltage_alarm;
    logic mains_undervoltage_alarm;
    logic external_fail_one_alarm;
    logic serial_link_alarm;
    logic fieldbus_alarm;
    logic external_fail_two_alarm;
    logic external_fail_three_alarm;
  } ifatl_alarm_s;

  typedef struct packed {
    logic ramps_zero;
    logic alt_gain_set_select;
    logic min_speed_positive_off;
    logic min_speed_negative_off;
    logic field_forcing_request;
    logic [1:0] jog_select;
    logic speed_loop_bypass;
    logic alarm_clear;
  } ifatl_ctrl_s;

  typedef struct packed {
    logic field_fail;
    logic load_loss;
    logic freq_unstable;
    logic mains_over;
    logic mains_under;
    logic below_three_quarter;
    logic regen_active;
    logic serial_msg_ok;
    logic fieldbus_msg_ok;
  } ifatl_cond_s;
endpackage

// >>> core/ifatl_top.sv
// Input function decode, timer outputs, motor potentiometer and alarm qualification.
// Assumes digital inputs and condition levels are synchronous-ish levels, one 100 MHz clock.
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
module ifatl_top
#(
  parameter int TICK_MS_CYC = ifatl_pkg::CYC_PER_MS,
  parameter int TICK_10MS_CYC = ifatl_pkg::CYC_PER_10MS
)
(
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic [ifatl_pkg::NUM_IN-1:0] DIG_IN,
  input wire ifatl_pkg::ifatl_cond_s COND,
  input wire logic AUTOTUNE_DONE,
  input wire logic [ifatl_pkg::REF_W-1:0] CUR_PERCENT,
  input wire logic [3:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output ifatl_pkg::ifatl_alarm_s ALARMS,
  output ifatl_pkg::ifatl_ctrl_s CTRL,
  output logic AUTOTUNE_TO_ALT,
  output logic [ifatl_pkg::REF_W-1:0] MOTOR_POT_REF,
  output logic [ifatl_pkg::REF_W-1:0] CURRENT_REF_MONITOR,
  output logic TIMER_A_OUT,
  output logic TIMER_B_OUT
);
  import ifatl_pkg::*;

  // Refused at elaboration: a zero-length tick would never fire
  if (TICK_MS_CYC < 1 || TICK_10MS_CYC < 1)
  begin
    $error("Tick periods must be at least one cycle");
  end

  logic [NUM_IN-1:0] in_meta_r, in_sync_r;
  logic [NUM_IN*CODE_W-1:0] func_sel_r;
  logic [15:0] mains_dly_r, ser_dly_r, fbus_dly_r, fld_time_r, pot_rate_r, cur_limit_r;
  logic [2:0] inhibit_r;
  logic [4:0] misc_r;
  logic [31:0] timer_a_cfg_r, timer_b_cfg_r;
  logic [31:0] tick_cnt_r, tick10_cnt_r;
  logic tick_ms, tick_10ms;

  // Two-stage synchroniser; the first stage feeds only the second
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      in_meta_r <= '0;
      in_sync_r <= '0;
    end
    else
    begin
      in_meta_r <= DIG_IN;
      in_sync_r <= in_meta_r;
    end
  end

  // Any closed input carrying the code activates it
  function automatic logic fn_active(input logic [NUM_IN*CODE_W-1:0] sel, input logic [NUM_IN-1:0] lvl,
                                     input logic [CODE_W-1:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_IN; i++)
      if (sel[i*CODE_W +: CODE_W] == code && lvl[i])
        hit = 1'b1;
    return hit;
  endfunction

  // Any input carrying the code exists and is open
  function automatic logic fn_open(input logic [NUM_IN*CODE_W-1:0] sel, input logic [NUM_IN-1:0] lvl,
                                   input logic [CODE_W-1:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_IN; i++)
      if (sel[i*CODE_W +: CODE_W] == code && !lvl[i])
        hit = 1'b1;
    return hit;
  endfunction

  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Millisecond and 10 ms enables
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      tick_cnt_r <= '0;
      tick10_cnt_r <= '0;
      tick_ms <= 1'b0;
      tick_10ms <= 1'b0;
    end
    else
    begin
      tick_ms <= (tick_cnt_r == 32'(TICK_MS_CYC - 1));
      tick_10ms <= (tick10_cnt_r == 32'(TICK_10MS_CYC - 1));
      tick_cnt_r <= (tick_cnt_r == 32'(TICK_MS_CYC - 1)) ? '0 : tick_cnt_r + 32'h1;
      tick10_cnt_r <= (tick10_cnt_r == 32'(TICK_10MS_CYC - 1)) ? '0 : tick10_cnt_r + 32'h1;
    end
  end

  // Register writes; mains, serial and fieldbus delays are clamped into their legal ranges
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      func_sel_r <= '0;
      mains_dly_r <= MAINS_DLY_RST;
      ser_dly_r <= LINK_DLY_RST;
      fbus_dly_r <= LINK_DLY_RST;
      inhibit_r <= '0;
      fld_time_r <= '0;
      pot_rate_r <= '0;
      timer_a_cfg_r <= '0;
      timer_b_cfg_r <= '0;
      cur_limit_r <= '0;
      misc_r <= '0;
    end
    else if (REG_WR)
    begin
      case (REG_ADDR)
        REG_FUNC_LO: func_sel_r[29:15] <= REG_WDATA[14:0];
        REG_FUNC_HI: func_sel_r[14:0] <= REG_WDATA[14:0];
        REG_MAINS_DLY: mains_dly_r <= clamp16(REG_WDATA[15:0], 16'h0000, MAINS_DLY_MAX);
        REG_SER_DLY: ser_dly_r <= clamp16(REG_WDATA[15:0], LINK_DLY_MIN, LINK_DLY_MAX);
        REG_FBUS_DLY: fbus_dly_r <= clamp16(REG_WDATA[15:0], LINK_DLY_MIN, LINK_DLY_MAX);
        REG_INHIBIT: inhibit_r <= REG_WDATA[2:0];
        REG_FLD_TIME: fld_time_r <= REG_WDATA[15:0];
        REG_POT_RATE: pot_rate_r <= REG_WDATA[15:0];
        REG_TIMER_A: timer_a_cfg_r <= REG_WDATA;
        REG_TIMER_B: timer_b_cfg_r <= REG_WDATA;
        REG_CUR_LIMIT: cur_limit_r <= REG_WDATA[15:0];
        REG_MISC: misc_r <= REG_WDATA[4:0];
        default: ;
      endcase
    end
  end

  // Decoded functions
  logic f_reset, f_slave, f_ramp, f_alt, f_minspd, f_fld, f_ja, f_jb, f_up, f_dn, f_clr, f_ta, f_tb;
  logic o_ext1, o_ext2, o_ext3;
  logic [1:0] pol;
  always_comb
  begin
    f_reset = fn_active(func_sel_r, in_sync_r, FN_RESET);
    f_slave = fn_active(func_sel_r, in_sync_r, FN_SLAVE);
    f_ramp = fn_active(func_sel_r, in_sync_r, FN_RAMP_OFF);
    f_alt = fn_active(func_sel_r, in_sync_r, FN_ALT_SET);
    f_minspd = fn_active(func_sel_r, in_sync_r, FN_MINSPD_OFF);
    f_fld = fn_active(func_sel_r, in_sync_r, FN_FLD_FORCE);
    f_ja = fn_active(func_sel_r, in_sync_r, FN_JOG_A);
    f_jb = fn_active(func_sel_r, in_sync_r, FN_JOG_B);
    f_up = fn_active(func_sel_r, in_sync_r, FN_UP);
    f_dn = fn_active(func_sel_r, in_sync_r, FN_DN);
    f_clr = fn_active(func_sel_r, in_sync_r, FN_POT_CLR);
    f_ta = fn_active(func_sel_r, in_sync_r, FN_TIMER_A);
    f_tb = fn_active(func_sel_r, in_sync_r, FN_TIMER_B);
    o_ext1 = fn_open(func_sel_r, in_sync_r, FN_EXT1);
    o_ext2 = fn_open(func_sel_r, in_sync_r, FN_EXT2);
    o_ext3 = fn_open(func_sel_r, in_sync_r, FN_EXT3);
    pol = misc_r[MISC_POL_LO +: 2];
  end

  // Field forcing holds for the programmed time in ms while the input stays closed
  logic [15:0] fld_cnt_r;
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      fld_cnt_r <= '0;
    else if (!f_fld)
      fld_cnt_r <= '0;
    else if (tick_ms && fld_cnt_r != fld_time_r)
      fld_cnt_r <= fld_cnt_r + 16'h1;
  end

  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      CTRL <= '0;
      AUTOTUNE_TO_ALT <= 1'b0;
    end
    else
    begin
      CTRL.ramps_zero <= f_ramp && !f_slave;
      CTRL.alt_gain_set_select <= f_alt;
      CTRL.min_speed_positive_off <= f_minspd && pol == POL_POS_ONLY;
      CTRL.min_speed_negative_off <= f_minspd && pol == POL_NEG_ONLY;
      CTRL.field_forcing_request <= f_fld && fld_cnt_r != fld_time_r;
      CTRL.jog_select <= {f_jb, f_ja};
      CTRL.speed_loop_bypass <= f_slave;
      CTRL.alarm_clear <= f_reset;
      // Write target follows the live selection when tuning finishes
      if (AUTOTUNE_DONE)
        AUTOTUNE_TO_ALT <= f_alt;
    end
  end

  // Motor potentiometer: one step per ms at the programmed rate
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      MOTOR_POT_REF <= '0;
    else if (f_clr)
      MOTOR_POT_REF <= '0;
    else if (misc_r[MISC_POT_USED] && tick_ms && f_up != f_dn)
    begin
      if (f_up)
        MOTOR_POT_REF <= (MOTOR_POT_REF > 16'hffff - pot_rate_r) ? 16'hffff : MOTOR_POT_REF + pot_rate_r;
      else
        MOTOR_POT_REF <= (MOTOR_POT_REF < pot_rate_r) ? 16'h0000 : MOTOR_POT_REF - pot_rate_r;
    end
  end

  // Slave current reference follows demand and sticks at the limit
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      CURRENT_REF_MONITOR <= '0;
    else
      CURRENT_REF_MONITOR <= (CUR_PERCENT > cur_limit_r) ? cur_limit_r : CUR_PERCENT;
  end

  // Timer outputs: config is {polarity, off delay [30:16] ms, on delay [14:0] ms}
  logic [14:0] ta_cnt_r, tb_cnt_r;
  logic ta_state_r, tb_state_r;
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ta_cnt_r <= '0;
      ta_state_r <= 1'b0;
    end
    else if (f_ta == ta_state_r)
      ta_cnt_r <= '0;
    else if (tick_ms)
    begin
      if (ta_cnt_r >= (f_ta ? timer_a_cfg_r[14:0] : timer_a_cfg_r[30:16]))
      begin
        ta_state_r <= f_ta;
        ta_cnt_r <= '0;
      end
      else
        ta_cnt_r <= ta_cnt_r + 15'h1;
    end
  end

  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      tb_cnt_r <= '0;
      tb_state_r <= 1'b0;
    end
    else if (f_tb == tb_state_r)
      tb_cnt_r <= '0;
    else if (tick_ms)
    begin
      if (tb_cnt_r >= (f_tb ? timer_b_cfg_r[14:0] : timer_b_cfg_r[30:16]))
      begin
        tb_state_r <= f_tb;
        tb_cnt_r <= '0;
      end
      else
        tb_cnt_r <= tb_cnt_r + 15'h1;
    end
  end

  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      TIMER_A_OUT <= 1'b0;
      TIMER_B_OUT <= 1'b0;
    end
    else
    begin
      TIMER_A_OUT <= ta_state_r ^ timer_a_cfg_r[31];
      TIMER_B_OUT <= tb_state_r ^ timer_b_cfg_r[31];
    end
  end

  // Trip-delay counters restart whenever the condition drops
  logic [15:0] ov_cnt_r, uv_cnt_r, ser_cnt_r, fb_cnt_r;
  logic uv_immediate;
  assign uv_immediate = COND.below_three_quarter || COND.regen_active;
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ov_cnt_r <= '0;
      uv_cnt_r <= '0;
      ser_cnt_r <= '0;
      fb_cnt_r <= '0;
    end
    else
    begin
      ov_cnt_r <= !COND.mains_over ? '0 : ((tick_ms && ov_cnt_r < mains_dly_r) ? ov_cnt_r + 16'h1 : ov_cnt_r);
      uv_cnt_r <= !COND.mains_under ? '0 : ((tick_ms && uv_cnt_r < mains_dly_r) ? uv_cnt_r + 16'h1 : uv_cnt_r);
      ser_cnt_r <= (COND.serial_msg_ok || !misc_r[MISC_SER_SRC]) ? '0 :
                   ((tick_10ms && ser_cnt_r < ser_dly_r) ? ser_cnt_r + 16'h1 : ser_cnt_r);
      fb_cnt_r <= (COND.fieldbus_msg_ok || !misc_r[MISC_FBUS_SRC]) ? '0 :
                  ((tick_10ms && fb_cnt_r < fbus_dly_r) ? fb_cnt_r + 16'h1 : fb_cnt_r);
    end
  end

  // Alarms latch until a reset input; a new trip in the clearing cycle wins
  ifatl_alarm_s trip;
  always_comb
  begin
    trip = '0;
    trip.field_failure_alarm = COND.field_fail && !inhibit_r[INH_FLD];
    trip.load_loss_alarm = COND.load_loss && !inhibit_r[INH_LOAD];
    trip.unstable_freq_alarm = COND.freq_unstable && !inhibit_r[INH_FREQ];
    trip.mains_overvoltage_alarm = COND.mains_over && ov_cnt_r >= mains_dly_r;
    trip.mains_undervoltage_alarm = COND.mains_under && (uv_immediate || uv_cnt_r >= mains_dly_r);
    trip.external_fail_one_alarm = o_ext1;
    trip.external_fail_two_alarm = o_ext2;
    trip.external_fail_three_alarm = o_ext3;
    trip.serial_link_alarm = misc_r[MISC_SER_SRC] && ser_cnt_r >= ser_dly_r;
    trip.fieldbus_alarm = misc_r[MISC_FBUS_SRC] && fb_cnt_r >= fbus_dly_r;
  end

  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      ALARMS <= '0;
    else
      ALARMS <= (f_reset ? '0 : ALARMS) | trip;
  end

  // Read port, data valid the cycle after the strobe
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      REG_RDATA <= '0;
    else if (REG_RD)
    begin
      case (REG_ADDR)
        REG_FUNC_LO: REG_RDATA <= {17'h0, func_sel_r[29:15]};
        REG_FUNC_HI: REG_RDATA <= {17'h0, func_sel_r[14:0]};
        REG_MAINS_DLY: REG_RDATA <= {16'h0, mains_dly_r};
        REG_SER_DLY: REG_RDATA <= {16'h0, ser_dly_r};
        REG_FBUS_DLY: REG_RDATA <= {16'h0, fbus_dly_r};
        REG_INHIBIT: REG_RDATA <= {29'h0, inhibit_r};
        REG_FLD_TIME: REG_RDATA <= {16'h0, fld_time_r};
        REG_POT_RATE: REG_RDATA <= {16'h0, pot_rate_r};
        REG_TIMER_A: REG_RDATA <= timer_a_cfg_r;
        REG_TIMER_B: REG_RDATA <= timer_b_cfg_r;
        REG_CUR_LIMIT: REG_RDATA <= {16'h0, cur_limit_r};
        REG_MISC: REG_RDATA <= {27'h0, misc_r};
        REG_ALARMS: REG_RDATA <= {22'h0, ALARMS};
        REG_POT_REF: REG_RDATA <= {16'h0, MOTOR_POT_REF};
        REG_STATUS: REG_RDATA <= {18'h0, in_sync_r, CTRL[7:0]};
        default: REG_RDATA <= '0;
      endcase
    end
    else
      REG_RDATA <= '0;
  end
endmodule

// >>> verification/ifatl_contacts.sv
// Behavioural contacts wired to the six programmable digital inputs.
// Assumes the bench asks for a contact pattern each clock; 1 means closed.
`timescale 1ns/100ps
module ifatl_contacts
(
  input wire logic mclk,
  input wire logic [5:0] close_req,
  output logic [5:0] contacts
);
  initial contacts = 6'h00;
  // Contacts move off the clock edge, as real wiring is unrelated to the clock
  always @(posedge mclk)
  begin
    contacts <= #3 close_req;
  end
endmodule

// >>> verification/ifatl_properties.sv
// Concurrent checks on the ports of the input function and alarm trip block.
// Assumes one clock domain with an active-low reset; bound to every top instance.
`timescale 1ns/100ps
module ifatl_properties
(
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic [ifatl_pkg::NUM_IN-1:0] DIG_IN,
  input wire ifatl_pkg::ifatl_cond_s COND,
  input wire logic AUTOTUNE_DONE,
  input wire logic [ifatl_pkg::REF_W-1:0] CUR_PERCENT,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire ifatl_pkg::ifatl_alarm_s ALARMS,
  input wire ifatl_pkg::ifatl_ctrl_s CTRL,
  input wire logic AUTOTUNE_TO_ALT,
  input wire logic [ifatl_pkg::REF_W-1:0] CURRENT_REF_MONITOR
);
  import ifatl_pkg::*;
  logic [9:0] alm_v;
  assign alm_v = ALARMS;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  sequence s_uv_fast;
    COND.mains_under && (COND.below_three_quarter || COND.regen_active);
  endsequence
  sequence s_uv_trip;
    ##[1:4] ALARMS.mains_undervoltage_alarm;
  endsequence
  a_rdata_idle_zero: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
    else $error("read data not zero outside the read slot");
  a_uv_fast_trip: assert property (s_uv_fast |-> s_uv_trip)
    else $error("undervoltage below three quarters did not trip at once");
  a_cur_ref_clamp: assert property (CURRENT_REF_MONITOR <= $past(CUR_PERCENT))
    else $error("current reference above demand");
  // A clear has to come from a closed input, since alarms are sticky
  a_alarm_clear_cause: assert property (|($past(alm_v) & ~alm_v) |->
    ($past(DIG_IN, 2) | $past(DIG_IN, 3) | $past(DIG_IN, 4) | $past(DIG_IN, 5)) != 6'h00)
    else $error("alarm cleared with no input closed");
  a_ext_needs_open: assert property ($rose(ALARMS.external_fail_one_alarm)
    || $rose(ALARMS.external_fail_two_alarm) || $rose(ALARMS.external_fail_three_alarm)
    |-> !(&$past(DIG_IN, 2)) || !(&$past(DIG_IN, 3)) || !(&$past(DIG_IN, 4)))
    else $error("external alarm with all inputs closed");
  // The target and the selection output are loaded on the same edge, so compare them together
  a_autotune_target: assert property (1'b1 |=> AUTOTUNE_TO_ALT ==
    ($past(AUTOTUNE_DONE) ? CTRL.alt_gain_set_select : $past(AUTOTUNE_TO_ALT)))
    else $error("autotune target set wrong");
  a_bypass_no_ramp: assert property (CTRL.speed_loop_bypass |-> !CTRL.ramps_zero)
    else $error("ramps forced while speed loop bypassed");
  a_minspd_exclusive: assert property (!(CTRL.min_speed_positive_off && CTRL.min_speed_negative_off))
    else $error("both minimum speeds suppressed");
endmodule
bind ifatl_top ifatl_properties ifatl_properties_i (.MCLK(MCLK), .RST_B(RST_B), .DIG_IN(DIG_IN), .COND(COND),
  .AUTOTUNE_DONE(AUTOTUNE_DONE), .CUR_PERCENT(CUR_PERCENT), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .ALARMS(ALARMS), .CTRL(CTRL), .AUTOTUNE_TO_ALT(AUTOTUNE_TO_ALT), .CURRENT_REF_MONITOR(CURRENT_REF_MONITOR));

// >>> verification/ifatl_top_test.sv
// Self-checking bench for the input function and alarm trip block.
// Assumes a 100 MHz clock and shortened ms ticks; contacts model drives the inputs.
`timescale 1ns/100ps
module ifatl_top_test;
  import ifatl_pkg::*;
  logic mclk = 0, rst_b = 0, wr = 0, rd = 0, at_done = 0;
  logic [3:0] addr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [5:0] req = 0, din, dig;
  logic [15:0] pct = 0, pot, cur;
  ifatl_cond_s cond = 9'h003;
  ifatl_alarm_s alm;
  ifatl_ctrl_s ctrl;
  logic to_alt, ta, tb;
  int fails = 0, checks_done = 0, seed = 92860;
  logic [4:0] codes [9] = '{5'h00, 5'h06, 5'h07, 5'h08, 5'h09, 5'h09, 5'h0b, 5'h0c, 5'h0d};
  int pols [9] = '{0, 0, 0, 0, 1, 2, 0, 0, 0};
  logic [2:0] inh [3] = '{3'h0, 3'h5, 3'h2};
  always #5 mclk = ~mclk;
  ifatl_contacts ifatl_contacts_i (.mclk(mclk), .close_req(req), .contacts(din));
  // Contact one lands on the top input bit, which carries the first code field
  assign dig = {din[0], din[1], din[2], din[3], din[4], din[5]};
  ifatl_top #(.TICK_MS_CYC(10), .TICK_10MS_CYC(100)) ifatl_top_i (.MCLK(mclk), .RST_B(rst_b), .DIG_IN(dig),
    .COND(cond), .AUTOTUNE_DONE(at_done), .CUR_PERCENT(pct), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .ALARMS(alm), .CTRL(ctrl), .AUTOTUNE_TO_ALT(to_alt),
    .MOTOR_POT_REF(pot), .CURRENT_REF_MONITOR(cur), .TIMER_A_OUT(ta), .TIMER_B_OUT(tb));
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk) wr <= 1'b0;
  endtask
  task rchk(input logic [3:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk) rd <= 1'b0;
    #1 cmp("reg", e, rdata);
  endtask
  // Five cycles covers contact delay, two sync stages and the output register
  task pins(input logic [5:0] v);
    @(posedge mclk) req <= v;
    cyc(5);
    #1;
  endtask
  task clr(input logic [5:0] b);
    pins(b | 6'h08);
    pins(b);
  endtask
  task setc(input logic [8:0] v);
    @(posedge mclk) cond <= v;
  endtask
  function automatic logic [8:0] exp_ctrl(input logic [4:0] code, input int pol);
    case (code)
      5'h00: return 9'h001;
      5'h06: return 9'h002;
      5'h07: return 9'h100;
      5'h08: return 9'h080;
      5'h09: return pol == 1 ? 9'h040 : 9'h020;
      5'h0b: return 9'h010;
      5'h0c: return 9'h004;
      5'h0d: return 9'h008;
      default: return 9'h000;
    endcase
  endfunction
  task wrap_up;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    cyc(30000);
    fails++;
    wrap_up;
  end
  initial
  begin
    cyc(6);
    rst_b <= 1'b1;
    rchk(REG_MAINS_DLY, 32'd1000);
    rchk(REG_SER_DLY, 32'd100);
    rchk(REG_FBUS_DLY, 32'd100);
    rchk(REG_INHIBIT, 32'h0);
    rchk(4'hf, 32'h0);
    wreg(REG_FLD_TIME, 32'd2);
    foreach (codes[k])
    begin
      wreg(REG_MISC, pols[k]);
      wreg(REG_FUNC_LO, {17'h0, codes[k], codes[k], 5'h0});
      pins(6'(({$random(seed)} % 3) + 1));
      cmp("ctrl", exp_ctrl(codes[k], pols[k]), ctrl);
      @(posedge mclk) at_done <= 1'b1;
      @(posedge mclk) at_done <= 1'b0;
      #1 cmp("alt", codes[k] == 5'h08, to_alt);
      cyc(40);
      #1 cmp("ctrl_late", codes[k] == 5'h0b ? 9'h0 : exp_ctrl(codes[k], pols[k]), ctrl);
      pins(6'h00);
      cmp("ctrl_off", 0, ctrl);
    end
    wreg(REG_FUNC_LO, {17'h0, FN_JOG_A, FN_JOG_B, 5'h0});
    pins(6'h03);
    cmp("jog", 9'h00c, ctrl);
    wreg(REG_TIMER_A, 32'h0000_0002);
    wreg(REG_FUNC_LO, {17'h0, FN_TIMER_A, FN_TIMER_B, 5'h0});
    pins(6'h03);
    cmp("timer", 0, ta);
    cyc(30);
    #1 cmp("timer", 1, ta);
    cmp("timer_b", 1, tb);
    pins(6'h00);
    cyc(12);
    #1 cmp("timer", 0, ta);
    cmp("timer_b", 0, tb);
    wreg(REG_TIMER_A, 32'h8000_0000);
    cyc(3);
    #1 cmp("timer_inv", 1, ta);
    wreg(REG_FUNC_LO, 32'h0);
    pins(6'h07);
    wreg(REG_FUNC_LO, {17'h0, FN_EXT1, FN_EXT2, FN_EXT3});
    pins(6'h05);
    pins(6'h07);
    cmp("alarms", 10'h002, alm);
    clr(6'h07);
    cmp("alarms", 0, alm);
    pins(6'h02);
    cmp("alarms", 10'h011, alm);
    pins(6'h07);
    wreg(REG_FUNC_LO, 32'h0);
    clr(6'h00);
    wreg(REG_MAINS_DLY, 32'd3000);
    rchk(REG_MAINS_DLY, 32'd2000);
    wreg(REG_MAINS_DLY, 32'd5);
    setc(9'h023);
    cyc(30);
    setc(9'h003);
    cyc(3);
    setc(9'h023);
    cyc(35);
    #1 cmp("mains", 0, alm);
    cyc(35);
    #1 cmp("mains", 10'h040, alm);
    setc(9'h003);
    clr(6'h00);
    setc(9'h01f);
    cyc(5);
    #1 cmp("uv_fast", 10'h020, alm);
    setc(9'h017);
    clr(6'h00);
    cmp("uv_fast", 10'h020, alm);
    setc(9'h003);
    clr(6'h00);
    setc(9'h013);
    cyc(20);
    #1 cmp("uv_slow", 0, alm);
    cyc(60);
    #1 cmp("uv_slow", 10'h020, alm);
    setc(9'h003);
    clr(6'h00);
    foreach (inh[k])
    begin
      wreg(REG_INHIBIT, inh[k]);
      setc(9'h1c3);
      cyc(5);
      #1 cmp("inhibit", {~inh[k][0], ~inh[k][1], ~inh[k][2], 7'h0}, alm);
      setc(9'h003);
      clr(6'h00);
    end
    wreg(REG_SER_DLY, 32'd50);
    rchk(REG_SER_DLY, 32'd100);
    wreg(REG_MISC, 32'h18);
    setc(9'h000);
    cyc(9000);
    #1 cmp("link", 0, alm);
    cyc(1500);
    #1 cmp("link", 10'h00c, alm);
    setc(9'h003);
    wreg(REG_MISC, 32'h0);
    clr(6'h00);
    wreg(REG_POT_RATE, 32'd3);
    wreg(REG_FUNC_HI, {17'h0, FN_DN, FN_UP, FN_POT_CLR});
    for (int u = 0; u < 2; u++)
    begin
      wreg(REG_MISC, u * 4);
      pins(6'h10);
      cyc(100);
      pins(6'h00);
      cmp("pot", 1, u ? (pot >= 27 && pot <= 39 && pot % 3 == 0) : pot == 0);
    end
    pins(6'h08);
    cyc(30);
    pins(6'h00);
    cmp("pot_dn", 1, pot >= 18 && pot <= 24 && pot % 3 == 0);
    pins(6'h20);
    cmp("pot_clr", 0, pot);
    wreg(REG_CUR_LIMIT, 32'd1000);
    repeat (20)
    begin
      @(posedge mclk) pct <= 16'($random(seed) % 2000);
      @(posedge mclk);
      #1 cmp("cur", pct < 1000 ? pct : 1000, cur);
    end
    wrap_up;
  end
endmodule
